// [hw/dba_device.sv]
// Behaviour
// - Delay buffer command two clocks before row start.
// - Ack high until buses released, then low.
// - Transparent mode grants only in blanking.
// - Shared mode blanks display, grants immediately.
// - Host requests before blanking rising edge.
// - Late request removal blanks next scan line.
// - Transparent mode: vertical blank grants only at front porch.
// - Delay grant two clocks before row start.
// - Row buffer: halt CPU, DMA row, release.
// - Halt request starts at blanking falling edge.
// - Row table: early halt, control at blank.
// - Table entry is low byte, six high bits.
// - Top two bits: attributes or address extension.
// - Fetch row start, advance pointer by two.
// - Cursor output marks fetch during blanking.
// - Fetched address loads primary screen start.
// - Host rewrites pointer every vertical retrace.
// - Host avoids device access during table reads; the host holds off new requests and commands then but keeps one already held.
// - Two master resets wake the device.
// - Mode from two low config bits.
// - Active-window commands run in horizontal blanking.
`default_nettype none
module dba_device
  import dba_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Link to the host.
  dba_if.device            link,
  // Timing and configuration from the rest of the controller.
  input  wire logic [7:0]  config_reg_zero,
  input  wire logic [7:0]  config_reg_two,
  input  wire logic        hblank,
  input  wire logic        vblank,
  input  wire logic        display_off,
  input  wire logic        front_porch_start,
  input  wire logic        hblank_second_last,
  input  wire logic        row_first_line_next,
  input  wire logic        last_line_mid,
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_load_value,
  // Row table results and row buffer DMA status.
  output logic [15:0]      primary_screen_start,
  output logic [15:0]      row_table_pointer,
  output logic [1:0]       row_attr,
  output logic             row_dma_busy
);
  import dba_pkg::*;

  // ---------------------------------------------------------------------------
  // Decode.
  // ---------------------------------------------------------------------------
  logic [1:0] mode;
  logic       rtbl_on;
  logic       dbl_attr;
  logic       blank_any;
  assign mode      = config_reg_zero[CFG0_MODE_LSB +: 2];
  assign rtbl_on   = config_reg_two[CFG2_RTBL_BIT];
  assign dbl_attr  = config_reg_zero[CFG0_DBL_BIT];
  assign blank_any = hblank | vblank;

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  dba_state_e  state_ff, nxt_state;
  logic [1:0]  rst_cnt_ff, nxt_rst_cnt;
  logic [1:0]  dly_ff, nxt_dly;
  logic [1:0]  byte_ff, nxt_byte;
  logic        fetch_ff, nxt_fetch;
  logic        late_ff, nxt_late;
  logic        cmd_pend_ff, nxt_cmd_pend;
  logic        cmd_exec_ff, nxt_cmd_exec;
  logic        hblank_d_ff, vblank_d_ff;
  logic [7:0]  lo_byte_ff, nxt_lo_byte;
  logic [15:0] pss_ff, nxt_pss;
  logic [15:0] ptr_ff, nxt_ptr;
  logic [1:0]  attr_ff, nxt_attr;
  logic        halt_ff, nxt_halt;
  logic        rbc_ff, nxt_rbc;
  logic        ready;
  logic        hb_rise, blank_fall, near_row, grant_ok;

  assign ready      = (rst_cnt_ff == 2'(RESET_CMDS_NEED));
  assign hb_rise    = hblank & ~hblank_d_ff;
  assign blank_fall = ~blank_any & (hblank_d_ff | vblank_d_ff);
  assign near_row   = rtbl_on & row_first_line_next;

  // Transparent grants wait for blanking; field blank grants only at front porch.
  always_comb begin
    grant_ok = 1'b0;
    if (mode == MODE_SHARED) begin
      grant_ok = 1'b1;
    end else if (mode == MODE_TRANSPARENT) begin
      if (vblank | display_off) begin
        grant_ok = front_porch_start;
      end else begin
        grant_ok = hblank;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Next-state logic for the arbiter, the fetch and the command path.
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_state    = state_ff;
    nxt_rst_cnt  = rst_cnt_ff;
    nxt_dly      = dly_ff;
    nxt_byte     = byte_ff;
    nxt_fetch    = fetch_ff;
    nxt_late     = late_ff;
    nxt_cmd_pend = cmd_pend_ff;
    nxt_cmd_exec = 1'b0;
    nxt_lo_byte  = lo_byte_ff;
    nxt_pss      = pss_ff;
    nxt_ptr      = ptr_ff;
    nxt_attr     = attr_ff;
    nxt_halt     = halt_ff;
    nxt_rbc      = rbc_ff;
    // Two master resets wake the device; a buffer command before the second restarts the count.
    if (!ready) begin
      if (link.master_reset_cmd) begin
        nxt_rst_cnt = rst_cnt_ff + 2'h1;
      end else if (link.buffer_cmd) begin
        nxt_rst_cnt = 2'h0;
      end
    end
    if (ptr_load) begin
      nxt_ptr = ptr_load_value;
    end
    // Buffer commands seen in the active window wait for horizontal blanking.
    if (cmd_pend_ff && (blank_any || display_off)) begin
      if (near_row && dly_ff != RTBL_DELAY_CHAR_CLOCK) begin
        nxt_dly = dly_ff + 2'h1;
      end else begin
        nxt_cmd_pend = 1'b0;
        nxt_cmd_exec = 1'b1;
        nxt_dly      = 2'h0;
      end
    end
    // A new command wins over the clear, so one arriving during execution is not lost.
    if (ready && link.buffer_cmd) begin
      nxt_cmd_pend = 1'b1;
    end
    // A request dropped after the next-to-last blanking clock blanks one more line.
    if (hblank_second_last) begin
      nxt_late = 1'b0;
    end else if (hblank && !link.cpu_buffer_request && state_ff == ARB_GRANT) begin
      nxt_late = 1'b1;
    end else if (hb_rise) begin
      nxt_late = 1'b0;
    end
    // Row table fetch: two bytes in blanking before a row's first scan line.
    if (ready && rtbl_on && hblank && row_first_line_next && !fetch_ff && byte_ff == 2'h0) begin
      nxt_fetch = 1'b1;
    end
    if (fetch_ff) begin
      nxt_byte = byte_ff + 2'h1;
      if (byte_ff == 2'h0) begin
        nxt_lo_byte = link.mem_data;
      end else begin
        nxt_fetch = 1'b0;
        nxt_ptr   = ptr_ff + PTR_STEP;
        if (dbl_attr) begin
          nxt_attr = link.mem_data[7:6];
          nxt_pss  = {2'h0, link.mem_data[ROW_HI_BITS-1:0], lo_byte_ff};
        end else begin
          nxt_attr = 2'h0;
          nxt_pss  = {link.mem_data, lo_byte_ff};
        end
      end
    end else if (!hblank) begin
      nxt_byte = 2'h0;
    end
    // Arbiter.
    case (state_ff)
      ARB_IDLE: begin
        if (ready && mode == MODE_ROW_BUFFER) begin
          if ((rtbl_on && last_line_mid) || (!rtbl_on && blank_fall && row_first_line_next)) begin
            nxt_halt  = 1'b1;
            nxt_state = ARB_HALT;
          end
        end else if (ready && link.cpu_buffer_request &&
                     (mode == MODE_SHARED || mode == MODE_TRANSPARENT)) begin
          nxt_state = ARB_WAIT;
        end
      end
      ARB_WAIT: begin
        if (!link.cpu_buffer_request) begin
          nxt_state = ARB_IDLE;
        end else if (grant_ok) begin
          if (near_row && dly_ff != RTBL_DELAY_CHAR_CLOCK) begin
            nxt_dly = dly_ff + 2'h1;
          end else begin
            nxt_dly   = 2'h0;
            nxt_state = ARB_RELEASE;
          end
        end
      end
      ARB_RELEASE: nxt_state = ARB_GRANT;
      ARB_GRANT: begin
        if (!link.cpu_buffer_request) begin
          nxt_state = ARB_RETURN;
        end
      end
      ARB_RETURN: nxt_state = ARB_IDLE;
      ARB_HALT: begin
        if (rtbl_on && hb_rise) begin
          nxt_rbc = 1'b1;
        end
        if (link.cpu_bus_released && (!rtbl_on || rbc_ff)) begin
          nxt_rbc   = 1'b1;
          nxt_state = ARB_DMA;
        end
      end
      ARB_DMA: begin
        if (!hblank && !fetch_ff && !row_first_line_next) begin
          nxt_halt  = 1'b0;
          nxt_rbc   = 1'b0;
          nxt_state = ARB_IDLE;
        end
      end
      default: nxt_state = ARB_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff    <= ARB_IDLE;
      rst_cnt_ff  <= 2'h0;
      dly_ff      <= 2'h0;
      byte_ff     <= 2'h0;
      fetch_ff    <= 1'b0;
      late_ff     <= 1'b0;
      cmd_pend_ff <= 1'b0;
      cmd_exec_ff <= 1'b0;
      hblank_d_ff <= 1'b0;
      vblank_d_ff <= 1'b0;
      lo_byte_ff  <= 8'h00;
      pss_ff      <= ADDR_RESET;
      ptr_ff      <= ADDR_RESET;
      attr_ff     <= 2'h0;
      halt_ff     <= 1'b0;
      rbc_ff      <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      rst_cnt_ff  <= nxt_rst_cnt;
      dly_ff      <= nxt_dly;
      byte_ff     <= nxt_byte;
      fetch_ff    <= nxt_fetch;
      late_ff     <= nxt_late;
      cmd_pend_ff <= nxt_cmd_pend;
      cmd_exec_ff <= nxt_cmd_exec;
      hblank_d_ff <= hblank;
      vblank_d_ff <= vblank;
      lo_byte_ff  <= nxt_lo_byte;
      pss_ff      <= nxt_pss;
      ptr_ff      <= nxt_ptr;
      attr_ff     <= nxt_attr;
      halt_ff     <= nxt_halt;
      rbc_ff      <= nxt_rbc;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs. Ack is held high until the release state has passed.
  // ---------------------------------------------------------------------------
  assign link.bus_ack_n            = (state_ff != ARB_GRANT);
  assign link.external_bus_release = (state_ff == ARB_RELEASE) || (state_ff == ARB_GRANT);
  assign link.cpu_halt_request     = halt_ff;
  assign link.row_buffer_control   = rbc_ff;
  assign link.cursor_out           = fetch_ff & blank_any;
  assign link.blank_out            = blank_any | late_ff |
                                     (mode == MODE_SHARED && state_ff == ARB_GRANT);
  assign link.cmd_exec             = cmd_exec_ff;
  assign link.device_ready         = ready;
  assign link.mem_addr             = ptr_ff + 16'(byte_ff);
  assign link.mem_rd               = fetch_ff;
  assign primary_screen_start      = pss_ff;
  assign row_table_pointer         = ptr_ff;
  assign row_attr                  = attr_ff;
  assign row_dma_busy              = (state_ff == ARB_DMA);
endmodule : dba_device
`default_nettype wire

// [hw/dba_host.sv]
`default_nettype none
module dba_host
  import dba_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Link to the device.
  dba_if.host             link,
  // User side.
  input  wire logic       user_access_req,
  input  wire logic       user_cmd_req,
  input  wire logic       row_table_busy,
  input  wire logic [7:0] user_mem_data,
  output logic            user_granted,
  output logic            init_done
);
  import dba_pkg::*;

  // ---------------------------------------------------------------------------
  // Start-up: two master resets back to back before anything else.
  // ---------------------------------------------------------------------------
  logic [1:0] boot_ff, nxt_boot;
  logic       req_ff, nxt_req;
  logic       cmd_ff, nxt_cmd;
  logic       rel_ff, nxt_rel;
  logic       gnt_ff, nxt_gnt;

  // Requests are raised ahead of blanking; new ones are held off during table reads, a held one stays.
  always_comb begin
    nxt_boot = boot_ff;
    nxt_cmd  = 1'b0;
    nxt_req  = 1'b0;
    if (boot_ff != 2'(RESET_CMDS_NEED)) begin
      nxt_boot = boot_ff + 2'h1;
    end else begin
      nxt_req = user_access_req & (~row_table_busy | req_ff);
      nxt_cmd = user_cmd_req & ~row_table_busy & ~cmd_ff;
    end
    // Buses are released whenever the device halts the CPU.
    nxt_rel = link.cpu_halt_request;
    nxt_gnt = ~link.bus_ack_n;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_ff <= 2'h0;
      req_ff  <= 1'b0;
      cmd_ff  <= 1'b0;
      rel_ff  <= 1'b0;
      gnt_ff  <= 1'b0;
    end else begin
      boot_ff <= nxt_boot;
      req_ff  <= nxt_req;
      cmd_ff  <= nxt_cmd;
      rel_ff  <= nxt_rel;
      gnt_ff  <= nxt_gnt;
    end
  end

  // Pointer rewrite in vertical retrace belongs to the software above this port.
  assign link.master_reset_cmd   = (boot_ff != 2'(RESET_CMDS_NEED)) & ~rst;
  assign link.cpu_buffer_request = req_ff;
  assign link.buffer_cmd         = cmd_ff;
  assign link.cpu_bus_released   = rel_ff;
  assign link.mem_data           = user_mem_data;
  assign user_granted            = gnt_ff;
  assign init_done               = link.device_ready;
endmodule : dba_host
`default_nettype wire

// [hw/dba_if.sv]
`default_nettype none
interface dba_if;
  // Host requests and resets.
  logic        cpu_buffer_request;
  logic        master_reset_cmd;
  logic        buffer_cmd;
  logic        cpu_bus_released;
  // Device handshake outputs.
  logic        bus_ack_n;
  logic        external_bus_release;
  logic        cpu_halt_request;
  logic        row_buffer_control;
  logic        cursor_out;
  logic        blank_out;
  logic        cmd_exec;
  logic        device_ready;
  // Memory read path used by row table fetches.
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic [7:0]  mem_data;

  modport device (
    input  cpu_buffer_request, master_reset_cmd, buffer_cmd, cpu_bus_released, mem_data,
    output bus_ack_n, external_bus_release, cpu_halt_request, row_buffer_control,
    output cursor_out, blank_out, cmd_exec, device_ready, mem_addr, mem_rd
  );
  modport host (
    output cpu_buffer_request, master_reset_cmd, buffer_cmd, cpu_bus_released, mem_data,
    input  bus_ack_n, external_bus_release, cpu_halt_request, row_buffer_control,
    input  cursor_out, blank_out, cmd_exec, device_ready, mem_addr, mem_rd
  );
endinterface : dba_if
`default_nettype wire

// [hw/dba_pkg.sv]
`default_nettype none
package dba_pkg;
  // ---------------------------------------------------------------------------
  // Operating modes, taken from the two low bits of config register zero.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] MODE_INDEPENDENT = 2'h0;
  localparam logic [1:0] MODE_TRANSPARENT = 2'h1;
  localparam logic [1:0] MODE_SHARED      = 2'h2;
  localparam logic [1:0] MODE_ROW_BUFFER  = 2'h3;

  // ---------------------------------------------------------------------------
  // Field positions and widths.
  // ---------------------------------------------------------------------------
  localparam int CFG0_MODE_LSB   = 0;
  localparam int CFG0_DBL_BIT    = 7;
  localparam int CFG2_RTBL_BIT   = 7;
  localparam int ADDR_W          = 16;
  localparam int ROW_LO_BITS     = 8;
  localparam int ROW_HI_BITS     = 6;
  localparam int RESET_CMDS_NEED = 2;

  // ---------------------------------------------------------------------------
  // Timing counts, in character clocks (one clock edge each), then fetch and address constants.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RTBL_DELAY_CHAR_CLOCK = 2'h2;
  localparam logic [1:0] FETCH_BYTES     = 2'h2;
  localparam logic [15:0] PTR_STEP       = 16'h0002;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;

  // ---------------------------------------------------------------------------
  // Arbiter states, Gray coded from idle through return along the grant path.
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ARB_IDLE    = 3'h0,
    ARB_WAIT    = 3'h1,
    ARB_RELEASE = 3'h3,
    ARB_GRANT   = 3'h2,
    ARB_RETURN  = 3'h6,
    ARB_HALT    = 3'h7,
    ARB_DMA     = 3'h5
  } dba_state_e;
endpackage : dba_pkg
`default_nettype wire

// [testbench/dba_assertions.sv]
`default_nettype none
module dba_assertions (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst,
  // Link signals.
  input wire logic        cpu_buffer_request,
  input wire logic        master_reset_cmd,
  input wire logic        bus_ack_n,
  input wire logic        external_bus_release,
  input wire logic        cursor_out,
  input wire logic        blank_out,
  input wire logic        device_ready,
  input wire logic        mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic        cpu_halt_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts reset commands; it saturates so a long run never wraps it.
  logic [1:0] mr_cnt_ff;
  logic [1:0] nxt_mr_cnt;
  always_comb begin
    nxt_mr_cnt = mr_cnt_ff;
    if (master_reset_cmd && mr_cnt_ff != 2'h2) begin
      nxt_mr_cnt = mr_cnt_ff + 2'h1;
    end
  end
  // Registers the count.
  always_ff @(posedge sys_clk) begin
    mr_cnt_ff <= rst ? 2'h0 : nxt_mr_cnt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ack_after_rel;
    $fell(bus_ack_n) |-> $past(external_bus_release) && $past(bus_ack_n);
  endproperty
  a_ack_after_rel: assert property (p_ack_after_rel) else $error("grant before release");
  property p_ack_not_early;
    $rose(cpu_buffer_request) |-> bus_ack_n [*3];
  endproperty
  a_ack_not_early: assert property (p_ack_not_early) else $error("grant too early");
  property p_ext_held;
    !bus_ack_n |-> external_bus_release;
  endproperty
  a_ext_held: assert property (p_ext_held) else $error("buses not freed");
  property p_return;
    !bus_ack_n && !cpu_buffer_request |=> bus_ack_n && !external_bus_release;
  endproperty
  a_return: assert property (p_return) else $error("grant not returned");
  property p_ready_two;
    device_ready |-> mr_cnt_ff == 2'h2;
  endproperty
  a_ready_two: assert property (p_ready_two) else $error("ready too soon");
  property p_idle_unready;
    !device_ready |-> bus_ack_n && !cpu_halt_request;
  endproperty
  a_idle_unready: assert property (p_idle_unready) else $error("active while not ready");
  property p_cursor_blank;
    cursor_out |-> blank_out;
  endproperty
  a_cursor_blank: assert property (p_cursor_blank) else $error("cursor outside blank");
  property p_fetch_cursor;
    mem_rd |-> cursor_out;
  endproperty
  a_fetch_cursor: assert property (p_fetch_cursor) else $error("fetch not flagged");
  property p_fetch_pair;
    $rose(mem_rd) |=> mem_rd && mem_addr == $past(mem_addr) + 16'h0001 ##1 !mem_rd;
  endproperty
  a_fetch_pair: assert property (p_fetch_pair) else $error("bad table read");
  c_grant: cover property ($fell(bus_ack_n));
  c_fetch: cover property ($rose(mem_rd));
  c_halt: cover property ($rose(cpu_halt_request));
endmodule : dba_assertions
`default_nettype wire

// [testbench/display_buffer_access_arbiter_tb.sv]
`default_nettype none
module display_buffer_access_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dba_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  cfg0    = 8'h00;
  logic [7:0]  cfg2    = 8'h00;
  logic        hblank  = 1'b0;
  logic        vblank  = 1'b0;
  logic        fp_go   = 1'b0;
  logic        hsl     = 1'b0;
  logic        llm     = 1'b0;
  logic        rfln    = 1'b0;
  logic        pld     = 1'b0;
  logic [15:0] pval    = 16'h0000;
  logic        acc_req = 1'b0;
  logic        cmd_req = 1'b0;
  logic [7:0]  mem_byte;
  logic [15:0] pss, rtp;
  logic [1:0]  attr;
  logic        granted_u, init_done;
  int          n_fail = 0, samples_checked = 0, cycles = 0, base, n;
  // Clock and a cycle ceiling that cuts a hang short.
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  dba_if dba_if_i ();
  // Table memory: the low byte sits at even addresses.
  assign mem_byte = dba_if_i.mem_addr[0] ? 8'hc5 : 8'h3a;
  dba_device dba_device_i (.sys_clk(sys_clk), .rst(rst), .link(dba_if_i.device),
    .config_reg_zero(cfg0), .config_reg_two(cfg2), .hblank(hblank), .vblank(vblank),
    .display_off(1'b0), .front_porch_start(fp_go), .hblank_second_last(hsl),
    .row_first_line_next(rfln), .last_line_mid(llm), .ptr_load(pld),
    .ptr_load_value(pval), .primary_screen_start(pss), .row_table_pointer(rtp),
    .row_attr(attr), .row_dma_busy());
  dba_host dba_host_i (.sys_clk(sys_clk), .rst(rst), .link(dba_if_i.host),
    .user_access_req(acc_req), .user_cmd_req(cmd_req), .row_table_busy(1'b0),
    .user_mem_data(mem_byte), .user_granted(granted_u), .init_done(init_done));
  dba_assertions dba_assertions_i (.sys_clk(sys_clk), .rst(rst),
    .cpu_buffer_request(dba_if_i.cpu_buffer_request),
    .master_reset_cmd(dba_if_i.master_reset_cmd), .bus_ack_n(dba_if_i.bus_ack_n),
    .external_bus_release(dba_if_i.external_bus_release), .cursor_out(dba_if_i.cursor_out),
    .blank_out(dba_if_i.blank_out), .device_ready(dba_if_i.device_ready),
    .mem_rd(dba_if_i.mem_rd), .mem_addr(dba_if_i.mem_addr),
    .cpu_halt_request(dba_if_i.cpu_halt_request));
  // Compares; an unknown never matches.
  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk1
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  function automatic logic pick(input int sel);
    case (sel)
      0: return init_done;
      1: return dba_if_i.cmd_exec;
      2: return dba_if_i.cpu_halt_request;
      3: return dba_if_i.row_buffer_control;
      default: return dba_if_i.bus_ack_n;
    endcase
  endfunction : pick
  // Bounded wait; the count of edges lets latencies be compared.
  task automatic wait_on(input int sel, input logic v, output int k);
    k = 0;
    #1; // Step off the edge so no output is read in the step that launches it.
    while (pick(sel) !== v && k < 40) begin
      tick(1);
      k++;
    end
  endtask : wait_on
  task automatic granted;
    chk1("bus_ack_n", 1'b0, dba_if_i.bus_ack_n);
    tick(1);
    chk1("user_granted", 1'b1, granted_u);
  endtask : granted
  task automatic drop;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    tick(4);
    chk1("bus_ack_n", 1'b1, dba_if_i.bus_ack_n);
    chk1("ext_release", 1'b0, dba_if_i.external_bus_release);
  endtask : drop
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence.
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    chk1("bus_ack_n", 1'b1, dba_if_i.bus_ack_n);
    wait_on(0, 1'b1, n);
    chk1("init_done", 1'b1, init_done);
    $display("test init done");
    @(posedge sys_clk);
    cfg0 <= {1'b1, 5'h00, MODE_SHARED};
    acc_req <= 1'b1;
    wait_on(4, 1'b0, base);
    chk16("grant latency", 16'h0004, 16'(base));
    granted();
    chk1("blank_out", 1'b1, dba_if_i.blank_out);
    drop();
    // A grant just before a row start costs two more clocks.
    @(posedge sys_clk);
    cfg2 <= 8'h80;
    rfln <= 1'b1;
    acc_req <= 1'b1;
    wait_on(4, 1'b0, n);
    chk16("grant latency", 16'h0006, 16'(n));
    drop();
    $display("test shared done");
    @(posedge sys_clk);
    cfg0 <= {1'b1, 5'h00, MODE_TRANSPARENT};
    cfg2 <= 8'h00;
    rfln <= 1'b0;
    acc_req <= 1'b1;
    tick(8);
    chk1("bus_ack_n", 1'b1, dba_if_i.bus_ack_n);
    @(posedge sys_clk);
    hblank <= 1'b1;
    wait_on(4, 1'b0, n);
    granted();
    drop();
    // Dropped before the next-to-last blanking clock: the next line shows.
    @(posedge sys_clk);
    hsl <= 1'b1;
    @(posedge sys_clk);
    hsl <= 1'b0;
    hblank <= 1'b0;
    tick(1);
    chk1("blank_out", 1'b0, dba_if_i.blank_out);
    // Dropped after it: the next line stays blanked.
    @(posedge sys_clk);
    hblank <= 1'b1;
    acc_req <= 1'b1;
    wait_on(4, 1'b0, n);
    granted();
    drop();
    @(posedge sys_clk);
    hblank <= 1'b0;
    tick(1);
    chk1("blank_out", 1'b1, dba_if_i.blank_out);
    @(posedge sys_clk);
    hblank <= 1'b0;
    vblank <= 1'b1;
    acc_req <= 1'b1;
    tick(8);
    chk1("bus_ack_n", 1'b1, dba_if_i.bus_ack_n);
    @(posedge sys_clk);
    fp_go <= 1'b1;
    @(posedge sys_clk);
    fp_go <= 1'b0;
    wait_on(4, 1'b0, n);
    granted();
    drop();
    $display("test transparent done");
    // A command in the active window waits for horizontal blanking, two more near a row.
    @(posedge sys_clk);
    vblank <= 1'b0;
    cfg0 <= {1'b0, 5'h00, MODE_INDEPENDENT};
    cfg2 <= 8'h80;
    rfln <= 1'b1;
    cmd_req <= 1'b1;
    @(posedge sys_clk);
    cmd_req <= 1'b0;
    tick(6);
    chk1("cmd_exec", 1'b0, dba_if_i.cmd_exec);
    @(posedge sys_clk);
    hblank <= 1'b1;
    wait_on(1, 1'b1, n);
    chk1("cmd_exec", 1'b1, dba_if_i.cmd_exec);
    chk16("cmd latency", 16'h0003, 16'(n));
    $display("test command done");
    @(posedge sys_clk);
    hblank <= 1'b0;
    pld <= 1'b1;
    pval <= 16'h0100;
    cfg2 <= 8'h80;
    @(posedge sys_clk);
    pld <= 1'b0;
    // Both readings of the two top bits of the second byte.
    for (int d = 1; d >= 0; d--) begin
      @(posedge sys_clk);
      cfg0 <= {d[0], 5'h00, MODE_SHARED};
      hblank <= 1'b1;
      rfln <= 1'b1;
      @(posedge sys_clk);
      rfln <= 1'b0;
      tick(4);
      chk16("screen_start", (d == 1) ? 16'h053a : 16'hc53a, pss);
      chk16("table_ptr", 16'h0104 - 16'(2 * d), rtp);
      if (d == 1) begin
        chk16("row_attr", 16'h0003, {14'h0000, attr});
      end
      @(posedge sys_clk);
      hblank <= 1'b0;
    end
    $display("test row table done");
    @(posedge sys_clk);
    cfg0 <= {1'b0, 5'h00, MODE_ROW_BUFFER};
    cfg2 <= 8'h00;
    hblank <= 1'b1;
    rfln <= 1'b1;
    tick(3);
    chk1("halt", 1'b0, dba_if_i.cpu_halt_request);
    @(posedge sys_clk);
    hblank <= 1'b0;
    wait_on(2, 1'b1, n);
    chk1("halt", 1'b1, dba_if_i.cpu_halt_request);
    wait_on(3, 1'b1, n);
    chk1("row_buf_ctl", 1'b1, dba_if_i.row_buffer_control);
    @(posedge sys_clk);
    rfln <= 1'b0;
    wait_on(2, 1'b0, n);
    chk1("halt", 1'b0, dba_if_i.cpu_halt_request);
    // With the row table on, halt comes mid last line and control at blanking.
    @(posedge sys_clk);
    cfg2 <= 8'h80;
    llm <= 1'b1;
    @(posedge sys_clk);
    llm <= 1'b0;
    tick(1);
    chk1("halt", 1'b1, dba_if_i.cpu_halt_request);
    chk1("row_buf_ctl", 1'b0, dba_if_i.row_buffer_control);
    @(posedge sys_clk);
    hblank <= 1'b1;
    wait_on(3, 1'b1, n);
    chk16("row_buf_ctl delay", 16'h0001, 16'(n));
    @(posedge sys_clk);
    hblank <= 1'b0;
    wait_on(2, 1'b0, n);
    chk1("halt", 1'b0, dba_if_i.cpu_halt_request);
    $display("test row buffer done");
    tally_and_finish();
  end
endmodule : display_buffer_access_arbiter_tb
`default_nettype wire
